// >>> inc/mbm_cfg.svh
`ifndef MBM_CFG_SVH
`define MBM_CFG_SVH
`define MBM_NB 5
`define MBM_DW 32
`define MBM_AW 8
`define MBM_CFG_W 14
`define MBM_A_CTRL 8'h00
`define MBM_A_CFG0 8'h04
`define MBM_A_STEP 8'h04
`define MBM_A_EVT 8'h18
`define MBM_A_STAT 8'h1C
`define MBM_A_DLY 8'h20
`define MBM_I_CTRL 4'h0
`define MBM_I_CFG0 4'h1
`define MBM_I_EVT 4'h6
`define MBM_I_STAT 4'h7
`define MBM_I_DLY 4'h8
`define MBM_I_NONE 4'hF
`define MBM_C_PRESET 0
`define MBM_C_LCPL 1
`define MBM_C_WALK 2
`define MBM_C_POL 3
`define MBM_C_BUSRET 8
`define MBM_C_DNLD 9
`define MBM_C_SWREQ 10
`define MBM_C_SWVAL 11
`define MBM_C_SWIMM 12
`define MBM_C_DARK 16
`define MBM_E_MOT 0
`define MBM_E_ON 8
`define MBM_E_OFF 16
`define MBM_E_DEND 24
`define MBM_S_DET 0
`define MBM_S_DIS 5
`define MBM_S_ACT 10
`define MBM_S_GRP 15
`define MBM_S_PEND 16
`define MBM_S_BIND 17
`define MBM_S_TRUN 22
`define MBM_CTRL_RST 32'h0000_0000
`define MBM_CFG_RST 14'h0000
`define MBM_RESP_OK 2'b00
`define MBM_RESP_ERR 2'b10
`define MBM_CLK_MHZ 200
`define MBM_TDLY_S 10
`define MBM_TDLY_CYC (`MBM_TDLY_S * `MBM_CLK_MHZ * 1000000)
`endif

// >>> inc/mbm_pkg.sv
`default_nettype none
package mbm_pkg;
  typedef enum logic [1:0] {APP_CEIL, APP_MOTION, APP_DETECTOR, APP_LIGHT} mbm_app_t;
  typedef enum logic [1:0] {TYP_SINGLE, TYP_MAIN, TYP_EXT, TYP_RSV} mbm_type_t;
  typedef enum logic [1:0] {MD_AUTO, MD_MANON, MD_MANOFF, MD_RSV} mbm_mode_t;
  typedef enum logic [1:0] {BH_NONE, BH_DISABLE, BH_DETECT, BH_RESTORE} mbm_beh_t;
  typedef enum logic [1:0] {GR_NONE, GR_ONE, GR_TWO, GR_RSV} mbm_grp_t;
  typedef enum logic [1:0] {ST_BASIC, ST_DETECT, ST_DISABLED} mbm_state_t;
  typedef struct packed {
    logic brightDep;
    logic en;
    mbm_grp_t grp;
    mbm_beh_t dlBeh;
    mbm_beh_t busBeh;
    mbm_mode_t mode;
    mbm_type_t typ;
    mbm_app_t app;
  } mbm_cfg_t;
  typedef struct packed {
    logic [4:0] beginTel;
    logic [4:0] endTel;
    logic [4:0] disTel;
  } mbm_tel_t;
endpackage : mbm_pkg
`default_nettype wire

// >>> verilog/mbm_mode_control.sv
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`include "mbm_cfg.svh"
`default_nettype none
module mbm_mode_control
  import mbm_pkg::*;
#(
  parameter logic [31:0] TDLY_CYC = 32'(`MBM_TDLY_CYC)
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`MBM_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`MBM_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`MBM_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [`MBM_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output mbm_tel_t tel,
  output logic presence,
  output logic lcDisable,
  output logic groupStatus,
  output logic groupStatusStb
);

  function automatic logic [3:0] mbm_idx(input logic [`MBM_AW-1:0] a);
    logic [3:0] r;
    r = `MBM_I_NONE;
    if (a == `MBM_A_CTRL)
      r = `MBM_I_CTRL;
    if (a == `MBM_A_EVT)
      r = `MBM_I_EVT;
    if (a == `MBM_A_STAT)
      r = `MBM_I_STAT;
    if (a == `MBM_A_DLY)
      r = `MBM_I_DLY;
    for (int k = 0; k < `MBM_NB; k++)
    begin
      if (a == `MBM_A_CFG0 + 8'(k) * `MBM_A_STEP)
        r = `MBM_I_CFG0 + 4'(k);
    end
    return r;
  endfunction : mbm_idx

  function automatic logic [`MBM_DW-1:0] mbm_merge(
    input logic [`MBM_DW-1:0] old,
    input logic [`MBM_DW-1:0] nw,
    input logic [3:0] strb
  );
    logic [`MBM_DW-1:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction : mbm_merge

  // Settings that the block cannot take are folded to legal ones
  function automatic mbm_cfg_t mbm_fix(input mbm_cfg_t raw, input int idx);
    mbm_cfg_t c;
    c = raw;
    if (c.app == APP_LIGHT && idx != 0)
      c.app = APP_CEIL;
    if (c.app == APP_DETECTOR)
      c.typ = TYP_SINGLE;
    if (c.typ == TYP_RSV || (c.app == APP_LIGHT && c.typ == TYP_EXT))
      c.typ = TYP_SINGLE;
    if (c.app == APP_MOTION || c.app == APP_DETECTOR || c.mode == MD_RSV)
      c.mode = MD_AUTO;
    if (c.app == APP_LIGHT && c.mode == MD_MANOFF)
      c.mode = MD_AUTO;
    if (idx == 0)
      c.en = 1'b1;
    if (c.grp == GR_RSV)
      c.grp = GR_NONE;
    return c;
  endfunction : mbm_fix

  logic [`MBM_DW-1:0] ctrl;
  logic [`MBM_DW-1:0] dly;
  logic [`MBM_DW-1:0] wData;
  logic [`MBM_AW-1:0] awAddr;
  logic [3:0] wStrb;
  mbm_cfg_t cfgReg [`MBM_NB];
  wire logic [`MBM_DW-1:0] mergeCfg [`MBM_NB];
  logic doWr;
  logic [3:0] wIdx;
  logic [3:0] rIdx;
  logic [`MBM_DW-1:0] rdVal;
  logic rdErr;
  logic [`MBM_DW-1:0] stat;
  logic evtWr;
  logic ctlWr;
  logic busEv;
  logic dlEv;
  logic swReq;
  logic swWant;
  logic anyDet;
  logic actGrp;
  logic pend;
  logic pendGrp;
  logic [`MBM_NB-1:0] motEv;
  logic [`MBM_NB-1:0] onEv;
  logic [`MBM_NB-1:0] offEv;
  logic [`MBM_NB-1:0] dEndEv;
  logic [`MBM_NB-1:0] swEnd;
  logic [`MBM_NB-1:0] dark;
  wire logic [`MBM_NB-1:0] detV;
  wire logic [`MBM_NB-1:0] disV;
  wire logic [`MBM_NB-1:0] actV;
  wire logic [`MBM_NB-1:0] inCur;
  wire logic [`MBM_NB-1:0] bindV;
  wire logic [`MBM_NB-1:0] trunV;
  wire logic [`MBM_NB-1:0] begV;
  wire logic [`MBM_NB-1:0] endV;
  wire logic [`MBM_NB-1:0] disTelV;
  wire logic [`MBM_NB-1:0] lcV;

  // Write channel: address and data taken in either order
  assign doWr = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign wIdx = mbm_idx(awAddr);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MBM_RESP_OK;
      awAddr <= '0;
      wData <= '0;
      wStrb <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wIdx == `MBM_I_NONE || wIdx == `MBM_I_STAT) ?
                       `MBM_RESP_ERR : `MBM_RESP_OK;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel
  assign rIdx = mbm_idx(s_axi_araddr);

  always_comb
  begin
    rdVal = '0;
    rdErr = 1'b0;
    for (int k = 0; k < `MBM_NB; k++)
    begin
      if (rIdx == `MBM_I_CFG0 + 4'(k))
        rdVal = 32'(mbm_fix(cfgReg[k], k));
    end
    case (rIdx)
      `MBM_I_CTRL: rdVal = ctrl;
      `MBM_I_STAT: rdVal = stat;
      `MBM_I_DLY: rdVal = dly;
      `MBM_I_NONE: rdErr = 1'b1;
      default: rdErr = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `MBM_RESP_OK;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rdata <= rdVal;
      s_axi_rresp <= rdErr ? `MBM_RESP_ERR : `MBM_RESP_OK;
      s_axi_rvalid <= 1'b1;
      s_axi_arready <= 1'b0;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Register storage
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl <= `MBM_CTRL_RST;
      dly <= TDLY_CYC;
      for (int k = 0; k < `MBM_NB; k++)
        cfgReg[k] <= mbm_cfg_t'(`MBM_CFG_RST);
    end
    else if (doWr)
    begin
      if (wIdx == `MBM_I_CTRL)
        ctrl <= mbm_merge(ctrl, wData, wStrb);
      if (wIdx == `MBM_I_DLY)
        dly <= mbm_merge(dly, wData, wStrb);
      for (int k = 0; k < `MBM_NB; k++)
      begin
        if (wIdx == `MBM_I_CFG0 + 4'(k))
          cfgReg[k] <= mbm_cfg_t'(mergeCfg[k][`MBM_CFG_W-1:0]);
      end
    end
  end

  // Event strobes from register writes
  assign evtWr = doWr && wIdx == `MBM_I_EVT;
  assign ctlWr = doWr && wIdx == `MBM_I_CTRL && wStrb[1];
  assign motEv = evtWr ? wData[`MBM_E_MOT +: `MBM_NB] : '0;
  assign onEv = evtWr ? wData[`MBM_E_ON +: `MBM_NB] : '0;
  assign offEv = evtWr ? wData[`MBM_E_OFF +: `MBM_NB] : '0;
  assign dEndEv = evtWr ? wData[`MBM_E_DEND +: `MBM_NB] : '0;
  assign busEv = ctlWr && wData[`MBM_C_BUSRET];
  assign dlEv = ctlWr && wData[`MBM_C_DNLD];
  assign swReq = ctlWr && wData[`MBM_C_SWREQ];
  assign swWant = wData[`MBM_C_SWVAL] ^ ctrl[`MBM_C_POL];
  assign dark = ctrl[`MBM_C_DARK +: `MBM_NB];
  assign anyDet = |(inCur & detV);
  assign swEnd = (swReq && wData[`MBM_C_SWIMM]) ? (inCur & detV) : '0;

  // Group selection and switch-over
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      actGrp <= 1'b0;
      pend <= 1'b0;
      pendGrp <= 1'b0;
      groupStatus <= 1'b0;
      groupStatusStb <= 1'b0;
    end
    else
    begin
      groupStatusStb <= 1'b0;
      if (busEv || dlEv)
      begin
        actGrp <= ctrl[`MBM_C_PRESET];
        pend <= 1'b0;
      end
      else if (swReq)
      begin
        groupStatusStb <= 1'b1;
        if (wData[`MBM_C_SWIMM] || !anyDet)
        begin
          actGrp <= swWant;
          pend <= 1'b0;
          groupStatus <= swWant ^ ctrl[`MBM_C_POL];
        end
        else
        begin
          pend <= 1'b1;
          pendGrp <= swWant;
          groupStatus <= actGrp ^ ctrl[`MBM_C_POL];
        end
      end
      else if (pend && !anyDet)
      begin
        actGrp <= pendGrp;
        pend <= 1'b0;
        groupStatus <= pendGrp ^ ctrl[`MBM_C_POL];
        groupStatusStb <= 1'b1;
      end
    end
  end

  // One detection block per instance
  for (genvar i = 0; i < `MBM_NB; i++)
  begin : g_blk
    mbm_cfg_t c;
    mbm_beh_t beh;
    mbm_state_t st;
    mbm_state_t prev;
    logic [`MBM_DW-1:0] tmr;
    logic tRun;
    logic bInd;
    logic bt;
    logic et;
    logic dt;
    logic lc;
    logic actNew;
    logic sel;
    logic cond;
    logic expired;
    logic ending;

    assign mergeCfg[i] = mbm_merge(32'(cfgReg[i]), wData, wStrb);
    assign c = mbm_fix(cfgReg[i], i);
    assign lc = (i == 0) && ctrl[`MBM_C_LCPL] && c.app == APP_LIGHT;
    assign lcV[i] = lc;
    assign inCur[i] = c.grp != GR_NONE && (c.grp == GR_TWO) == actGrp;
    assign actV[i] = c.en && !ctrl[`MBM_C_WALK] &&
                     (c.grp == GR_NONE || (c.grp == GR_TWO) == actGrp);
    assign actNew = c.en && !ctrl[`MBM_C_WALK] &&
                    (c.grp == GR_NONE || (c.grp == GR_TWO) == ctrl[`MBM_C_PRESET]);
    assign sel = actNew && c.typ != TYP_EXT;
    assign beh = dlEv ? ((c.dlBeh == BH_RESTORE) ? BH_NONE : c.dlBeh) : c.busBeh;
    assign cond = !c.brightDep || dark[i];
    assign expired = tRun && tmr == '0;
    assign ending = actV[i] && st == ST_DETECT &&
                    ((offEv[i] && c.mode != MD_AUTO) || (expired && !motEv[i]));

    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        st <= ST_BASIC;
        prev <= ST_BASIC;
        tmr <= '0;
        tRun <= 1'b0;
        bInd <= 1'b0;
        bt <= 1'b0;
        et <= 1'b0;
        dt <= 1'b0;
      end
      else
      begin
        bt <= 1'b0;
        et <= 1'b0;
        dt <= 1'b0;
        if (tRun && tmr != '0)
          tmr <= tmr - 32'h0000_0001;
        if ((busEv || dlEv) && sel)
        begin
          unique case (beh)
            BH_NONE:
            begin
              st <= ST_BASIC;
              tRun <= 1'b0;
            end
            BH_DISABLE:
            begin
              st <= ST_DISABLED;
              prev <= ST_BASIC;
              tRun <= 1'b0;
              dt <= !lc;
            end
            BH_DETECT:
            begin
              st <= ST_DETECT;
              tRun <= 1'b1;
              tmr <= dly;
              bt <= !lc;
              bInd <= cond;
            end
            BH_RESTORE: st <= st;
          endcase
        end
        else if (swEnd[i] || ending)
        begin
          st <= ST_BASIC;
          tRun <= 1'b0;
          et <= !lc;
        end
        else if (actV[i])
        begin
          unique case (st)
            ST_BASIC:
            begin
              if ((c.mode == MD_MANON) ? onEv[i] : (motEv[i] && cond))
              begin
                st <= ST_DETECT;
                tRun <= c.mode != MD_MANOFF;
                tmr <= dly;
                bt <= !lc;
                bInd <= cond;
              end
            end
            ST_DETECT:
            begin
              if (motEv[i] && tRun)
                tmr <= dly;
            end
            ST_DISABLED:
            begin
              if (dEndEv[i])
                st <= prev;
            end
            default: st <= ST_BASIC;
          endcase
        end
      end
    end

    assign detV[i] = st == ST_DETECT;
    assign disV[i] = st == ST_DISABLED;
    assign bindV[i] = bInd;
    assign trunV[i] = tRun;
    assign begV[i] = bt;
    assign endV[i] = et;
    assign disTelV[i] = dt;
  end

  assign tel = '{beginTel: begV, endTel: endV, disTel: disTelV};

  // Light-control indications of the first block
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      presence <= 1'b0;
      lcDisable <= 1'b0;
    end
    else
    begin
      presence <= lcV[0] && detV[0];
      lcDisable <= lcV[0] && disV[0];
    end
  end

  always_comb
  begin
    stat = '0;
    stat[`MBM_S_DET +: `MBM_NB] = detV;
    stat[`MBM_S_DIS +: `MBM_NB] = disV;
    stat[`MBM_S_ACT +: `MBM_NB] = actV;
    stat[`MBM_S_GRP] = actGrp;
    stat[`MBM_S_PEND] = pend;
    stat[`MBM_S_BIND +: `MBM_NB] = bindV;
    stat[`MBM_S_TRUN +: `MBM_NB] = trunV;
  end

endmodule : mbm_mode_control
`default_nettype wire

// >>> sim/mbm_mode_monitor.sv
`include "mbm_cfg.svh"
`default_nettype none
module mbm_mode_monitor
  import mbm_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`MBM_DW-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire mbm_tel_t tel,
  input wire logic presence,
  input wire logic lcDisable,
  input wire logic groupStatus,
  input wire logic groupStatusStb
);
  timeunit 1ns;
  timeprecision 1ps;
  logic bvPrev;
  logic bRise;
  logic [14:0] telBits;
  always_ff @(posedge clk)
  begin
    bvPrev <= sys_rst ? 1'b0 : s_axi_bvalid;
  end
  assign bRise = s_axi_bvalid & ~bvPrev;
  assign telBits = tel;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Both halves of a write taken while idle
  sequence wrTake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence bAnswer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  AST_WR_ANSWER: assert property (wrTake |=> bAnswer)
    else $error("write answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_TEL_PULSE: assert property (telBits != 15'h0000 |=> (telBits & $past(telBits)) == 15'h0000)
    else $error("telegram longer than one cycle");
  AST_BEGIN_CAUSE: assert property ((|tel.beginTel) || (|tel.disTel) |-> bRise)
    else $error("begin or disable telegram without event");
  AST_BEGIN_END: assert property ((tel.beginTel & tel.endTel) == 5'h00)
    else $error("begin and end together");
  AST_DIS_EXCL: assert property ((tel.disTel & (tel.beginTel | tel.endTel)) == 5'h00)
    else $error("disable with detection telegram");
  AST_PRES_DIS: assert property (!(presence && lcDisable))
    else $error("presence while disabled");
  AST_PRES_CAUSE: assert property ($rose(presence) || $rose(lcDisable) |-> $past(bRise))
    else $error("light indication without event");
  AST_GRP_STB: assert property ($changed(groupStatus) |-> groupStatusStb)
    else $error("group status changed silently");
endmodule : mbm_mode_monitor
bind mbm_mode_control mbm_mode_monitor i_mon (.clk(clk), .sys_rst(sys_rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tel(tel), .presence(presence),
  .lcDisable(lcDisable), .groupStatus(groupStatus), .groupStatusStb(groupStatusStb));
`default_nettype wire

// >>> sim/mbm_bus_model.sv
`default_nettype none
module mbm_bus_model
  import mbm_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire mbm_tel_t tel,
  input wire logic groupStatusStb,
  output int nBegin [5],
  output int nEnd [5],
  output int nDis [5],
  output int nStb
);
  timeunit 1ns;
  timeprecision 1ps;
  // Actuator side: counts every telegram seen on the bus
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 5; i++)
    begin
      nBegin[i] <= sys_rst ? 0 : nBegin[i] + int'(tel.beginTel[i]);
      nEnd[i] <= sys_rst ? 0 : nEnd[i] + int'(tel.endTel[i]);
      nDis[i] <= sys_rst ? 0 : nDis[i] + int'(tel.disTel[i]);
    end
    nStb <= sys_rst ? 0 : nStb + int'(groupStatusStb);
  end
endmodule : mbm_bus_model
`default_nettype wire

// >>> sim/tb.sv
`include "mbm_cfg.svh"
`default_nettype none
module tb
  import mbm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLY = 20;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, presence, lcDisable, grpSt, grpStb;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  mbm_tel_t tel;
  int nb [5], ne [5], nd [5], ns;
  int fails = 0, nChecks = 0;
  always #2.5 clk = ~clk;
  mbm_mode_control #(.TDLY_CYC(32'd20)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tel(tel), .presence(presence), .lcDisable(lcDisable), .groupStatus(grpSt),
    .groupStatusStb(grpStb));
  mbm_bus_model i_bus (.clk(clk), .sys_rst(sys_rst), .tel(tel), .groupStatusStb(grpStb),
    .nBegin(nb), .nEnd(ne), .nDis(nd), .nStb(ns));
  task automatic close_out();
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(awDone && wDone))
    begin
      @(posedge clk);
      if (awready && !awDone)
      begin
        awvalid <= 1'b0;
        awDone = 1'b1;
      end
      if (wready && !wDone)
      begin
        wvalid <= 1'b0;
        wDone = 1'b1;
      end
    end
    repeat ($urandom_range(2)) @(posedge clk);
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    check("bresp", bresp, er);
  endtask : wr
  task automatic rdw(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    repeat ($urandom_range(2)) @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    check("rdata", rdata, exp);
    check("rresp", rresp, er);
  endtask : rdw
  function automatic logic [7:0] ca(input int n);
    return 8'(`MBM_A_CFG0 + `MBM_A_STEP * n);
  endfunction : ca
  function automatic logic [31:0] cf(input mbm_app_t a, input mbm_type_t t, input mbm_mode_t m,
    input mbm_beh_t b, input mbm_beh_t d, input mbm_grp_t g, input logic bd);
    mbm_cfg_t c;
    c = '{brightDep: bd, en: 1'b1, grp: g, dlBeh: d, busBeh: b, mode: m, typ: t, app: a};
    return 32'(c);
  endfunction : cf
  function automatic logic [31:0] fold(input int n, input mbm_cfg_t c);
    if (c.app == APP_LIGHT && n > 0)
      c.app = APP_CEIL;
    if (c.app == APP_DETECTOR || c.typ == TYP_RSV || (c.app == APP_LIGHT && c.typ == TYP_EXT))
      c.typ = TYP_SINGLE;
    if (c.app inside {APP_MOTION, APP_DETECTOR} || c.mode == MD_RSV)
      c.mode = MD_AUTO;
    if (c.app == APP_LIGHT && c.mode == MD_MANOFF)
      c.mode = MD_AUTO;
    if (c.grp == GR_RSV)
      c.grp = GR_NONE;
    if (n == 0)
      c.en = 1'b1;
    return 32'(c);
  endfunction : fold
  task automatic ev(input int k, input int n);
    wr(`MBM_A_EVT, 32'h0000_0001 << (k + n), `MBM_RESP_OK);
    idle(3);
  endtask : ev
  task automatic rs(input logic [31:0] cfg, input logic [31:0] ctl, input int eb, input int ed);
    int b0;
    int d0;
    wr(ca(4), cfg, `MBM_RESP_OK);
    b0 = nb[4];
    d0 = nd[4];
    wr(`MBM_A_CTRL, ctl, `MBM_RESP_OK);
    idle(3);
    check("restartBegin", nb[4] - b0, eb);
    check("restartDisable", nd[4] - d0, ed);
  endtask : rs
  task automatic rst();
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
  endtask : rst
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end
  initial
  begin
    int n;
    mbm_cfg_t c;
    void'($urandom(32'hd12d064a));
    rst();
    rdw(`MBM_A_CTRL, `MBM_CTRL_RST, `MBM_RESP_OK);
    rdw(`MBM_A_DLY, DLY, `MBM_RESP_OK);
    rdw(8'h40, 32'h0000_0000, `MBM_RESP_ERR);
    wr(`MBM_A_STAT, 32'hFFFF_FFFF, `MBM_RESP_ERR);
    repeat (16)
    begin
      n = $urandom_range(4);
      c = mbm_cfg_t'(14'($urandom));
      wr(ca(n), 32'(c), `MBM_RESP_OK);
      rdw(ca(n), fold(n, c), `MBM_RESP_OK);
    end
    rst();
    wr(ca(1), cf(APP_CEIL, TYP_SINGLE, MD_AUTO, BH_NONE, BH_NONE, GR_NONE, 0), `MBM_RESP_OK);
    ev(`MBM_E_MOT, 1);
    check("autoBegin", nb[1], 1);
    idle(6);
    ev(`MBM_E_MOT, 1);
    idle(12);
    check("reloadEnd", ne[1], 0);
    idle(10);
    check("delayEnd", ne[1], 1);
    wr(ca(2), cf(APP_CEIL, TYP_SINGLE, MD_MANON, BH_NONE, BH_NONE, GR_NONE, 0), `MBM_RESP_OK);
    ev(`MBM_E_MOT, 2);
    check("manOnIdle", nb[2], 0);
    ev(`MBM_E_ON, 2);
    check("manOnBegin", nb[2], 1);
    ev(`MBM_E_OFF, 2);
    check("manOnEnd", ne[2], 1);
    ev(`MBM_E_MOT, 2);
    check("manOnRearm", nb[2], 1);
    wr(ca(3), cf(APP_CEIL, TYP_SINGLE, MD_MANOFF, BH_NONE, BH_NONE, GR_NONE, 0), `MBM_RESP_OK);
    ev(`MBM_E_MOT, 3);
    check("manOffBegin", nb[3], 1);
    idle(40);
    check("manOffHold", ne[3], 0);
    ev(`MBM_E_OFF, 3);
    check("manOffEnd", ne[3], 1);
    rs(cf(APP_CEIL, TYP_SINGLE, MD_AUTO, BH_NONE, BH_NONE, GR_NONE, 0), 32'h0000_0100, 0, 0);
    rs(cf(APP_CEIL, TYP_MAIN, MD_AUTO, BH_DISABLE, BH_NONE, GR_NONE, 0), 32'h0000_0100, 0, 1);
    rs(cf(APP_CEIL, TYP_SINGLE, MD_AUTO, BH_DETECT, BH_NONE, GR_NONE, 0), 32'h0000_0100, 1, 0);
    idle(25);
    check("restartEnd", ne[4], 1);
    rs(cf(APP_CEIL, TYP_SINGLE, MD_AUTO, BH_DETECT, BH_NONE, GR_NONE, 1), 32'h0000_0100, 1, 0);
    idle(25);
    rs(cf(APP_CEIL, TYP_EXT, MD_AUTO, BH_DISABLE, BH_NONE, GR_NONE, 0), 32'h0000_0100, 0, 0);
    rs(cf(APP_CEIL, TYP_SINGLE, MD_AUTO, BH_NONE, BH_DISABLE, GR_NONE, 0), 32'h0000_0300, 0, 1);
    rs(cf(APP_CEIL, TYP_SINGLE, MD_AUTO, BH_DETECT, BH_NONE, GR_TWO, 0), 32'h0000_0100, 0, 0);
    rs(cf(APP_CEIL, TYP_SINGLE, MD_AUTO, BH_RESTORE, BH_NONE, GR_NONE, 0), 32'h0000_0100, 0, 0);
    rdw(`MBM_A_STAT, 32'h001C_7E00, `MBM_RESP_OK);
    wr(`MBM_A_CTRL, 32'h0000_0002, `MBM_RESP_OK);
    wr(ca(0), cf(APP_LIGHT, TYP_SINGLE, MD_AUTO, BH_DETECT, BH_NONE, GR_NONE, 0), `MBM_RESP_OK);
    wr(`MBM_A_CTRL, 32'h0000_0102, `MBM_RESP_OK);
    idle(3);
    check("presence", presence, 1'b1);
    check("lightBegin", nb[0], 0);
    wr(ca(0), cf(APP_LIGHT, TYP_MAIN, MD_AUTO, BH_DISABLE, BH_NONE, GR_NONE, 0), `MBM_RESP_OK);
    wr(`MBM_A_CTRL, 32'h0000_0102, `MBM_RESP_OK);
    idle(3);
    check("lcDisable", lcDisable, 1'b1);
    check("presenceOff", presence, 1'b0);
    wr(ca(0), cf(APP_LIGHT, TYP_SINGLE, MD_AUTO, BH_NONE, BH_NONE, GR_NONE, 0), `MBM_RESP_OK);
    wr(`MBM_A_CTRL, 32'h0000_0102, `MBM_RESP_OK);
    idle(3);
    check("lightBasic", {presence, lcDisable}, 2'b00);
    wr(`MBM_A_CTRL, 32'h0000_0000, `MBM_RESP_OK);
    wr(ca(1), cf(APP_CEIL, TYP_SINGLE, MD_AUTO, BH_NONE, BH_NONE, GR_ONE, 0), `MBM_RESP_OK);
    ev(`MBM_E_MOT, 1);
    wr(`MBM_A_CTRL, 32'h0000_1C00, `MBM_RESP_OK);
    idle(3);
    check("switchEnd", ne[1], 2);
    check("switchStatus", grpSt, 1'b1);
    check("switchStb", ns, 1);
    ev(`MBM_E_MOT, 1);
    check("inactiveBegin", nb[1], 2);
    close_out();
  end
endmodule : tb
`default_nettype wire
